// *** common/srr_map.vh ***
// Constants for the serial register read slave: opcodes, field positions and counts.
`ifndef SRR_MAP_VH
`define SRR_MAP_VH

// Read opcodes.
`define SRR_OPC_READ      8'h03
`define SRR_OPC_FAST      8'h0B
`define SRR_OPC_DUAL      8'h3B
`define SRR_OPC_QUAD      8'h6B

// Master byte that marks the last basic read output byte.
`define SRR_LAST_MARK     8'hFF
`define SRR_DUMMY_BYTE    8'h00

// Dummy configuration word layout: three 8-bit counts.
`define SRR_DUM_INIT_LSB  0
`define SRR_DUM_INTRA_LSB 8
`define SRR_DUM_INTER_LSB 16

// Least initial dummy counts per command type.
`define SRR_MIN_DUM_READ  8'h00
`define SRR_MIN_DUM_SPI   8'h01
`define SRR_MIN_DUM_QUAD  8'h03

// DWORD address mode in address bits 15:14.
`define SRR_MODE_INC      2'h1
`define SRR_MODE_DEC      2'h2

// Bit of the first length byte that selects the 14-bit length form.
`define SRR_LEN_LONG_BIT  7

// Lane widths, bits per byte and last byte offset in a DWORD.
`define SRR_W1            4'h1
`define SRR_W2            4'h2
`define SRR_W4            4'h4
`define SRR_BYTE_BITS     4'h8
`define SRR_LAST_OFS      2'h3

// Output enables per output width; single lane drives lane 1.
`define SRR_OE_W1         4'h2
`define SRR_OE_W2         4'h3
`define SRR_OE_W4         4'hF

// Pin synchroniser reset value: select high, clock and lanes low.
`define SRR_SYNC_RST      6'h20

`endif

// *** design/srr_pin_sync.v ***
// Two-flop synchroniser for the serial link pins.
`timescale 1ns/1ns
module srr_pin_sync #(
  parameter       W       = 6,
  parameter [5:0] RST_VAL = 6'h00
) (
  // Clock and reset
  input  wire         core_clk,
  input  wire         rstn,
  // Pins and synchronised copies
  input  wire [W-1:0] pin_raw,
  output wire [W-1:0] pin_sync
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          meta_q[i] <= RST_VAL[i];
          sync_q[i] <= RST_VAL[i];
        end else begin
          meta_q[i] <= pin_raw[i];
          sync_q[i] <= meta_q[i];
        end
      end
    end
  endgenerate

  assign pin_sync = sync_q;

endmodule // srr_pin_sync

// *** design/srr_read_slave.v ***
// Serial read slave: opcode decode, header capture, dummy insertion and lane output.
//
// Functional notes
// - Snapshot the addressed 32-bit register at each DWORD start; shift out the copy.
// - Opcode 03h is the basic read, single-lane mode only, up to 30 MHz.
// - Basic read: two address bytes one bit per clock, then 0 to 255 dummies.
// - Basic read output starts on the fall after the last header bit, MSB first.
// - Later bits follow on each fall, straight after the prior byte or dummies.
// - Select high ends the basic read and releases the serial output pin.
// - No dummy bytes follow the final data byte; partial reads just stop.
// - Opcode 0Bh is the fast read in single- and quad-lane modes.
// - Fast read header: address, length, dummies; quad mode needs 3 or more.
// - Length counts data bytes only; 7-bit or 14-bit form.
// - Unaligned length reads send 1-3 uncounted padding bytes before data.
// - Quad fast read drives four lanes, high nibble first; released on deselect.
// - Opcode 3Bh is the dual-output read, single-lane mode only.
// - Dual output drives two lanes after the last dummy bit, high pair first.
// - Opcode 6Bh is the quad-output read, single-lane mode only.
// - Select high ends the dual-output read and releases both lanes.
// - Address bits 15:14 pick hold, increment or decrement of the DWORD address.
// - Initial, intra-DWORD and inter-DWORD dummy counts; inter alone at boundaries.
// - DWORD boundary comes from the last byte address, not a byte count.
`timescale 1ns/1ns
`include "srr_map.vh"
module srr_read_slave (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rstn,
  // Serial link pins
  input  wire        serial_clk,
  input  wire        serial_select_n,
  input  wire [3:0]  quad_data_lanes,
  output reg  [3:0]  quad_data_lanes_drv,
  output reg  [3:0]  quad_data_lanes_oe,
  // Configuration
  input  wire        quad_lane_mode,
  input  wire [23:0] dummy_cfg_read,
  input  wire [23:0] dummy_cfg_fast,
  input  wire [23:0] dummy_cfg_dual,
  input  wire [23:0] dummy_cfg_quad,
  // Register fetch port
  output reg         mem_req,
  output reg  [13:0] mem_addr,
  input  wire        mem_ack,
  input  wire [31:0] mem_rdata,
  // Status
  output reg         read_busy,
  output reg         bad_opcode
);

  localparam [7:0] ST_OPC  = 8'h01;
  localparam [7:0] ST_AH   = 8'h02;
  localparam [7:0] ST_AL   = 8'h04;
  localparam [7:0] ST_L1   = 8'h08;
  localparam [7:0] ST_L2   = 8'h10;
  localparam [7:0] ST_IDUM = 8'h20;
  localparam [7:0] ST_DATA = 8'h40;
  localparam [7:0] ST_SKIP = 8'h80;

  wire [5:0] pins_s;
  srr_pin_sync #(
    .W       (6),
    .RST_VAL (`SRR_SYNC_RST)
  ) u_sync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .pin_raw  ({serial_select_n, serial_clk, quad_data_lanes}),
    .pin_sync (pins_s)
  );

  wire       sel_idle = pins_s[5];
  wire       sclk_s   = pins_s[4];
  wire [3:0] lanes_s  = pins_s[3:0];

  reg        sclk_q;
  reg [7:0]  st_q;
  reg        qmode_q;
  reg [7:0]  in_sr_q;
  reg [3:0]  in_cnt_q;
  reg        is_read_q;
  reg [3:0]  ow_q;
  reg [3:0]  oe_mask_q;
  reg [7:0]  intra_q;
  reg [7:0]  inter_q;
  reg [7:0]  idum_q;
  reg [1:0]  mode_q;
  reg [11:0] dw_q;
  reg [1:0]  bofs_q;
  reg [1:0]  pad_left_q;
  reg [13:0] len_left_q;
  reg [31:0] snap_q;
  reg [7:0]  out_sr_q;
  reg [3:0]  out_cnt_q;
  reg [7:0]  dum_left_q;
  reg        cur_data_q;
  reg        fin_q;

  wire       rise = sclk_s & ~sclk_q;
  wire       fall = ~sclk_s & sclk_q;
  wire [3:0] iw   = qmode_q ? `SRR_W4 : `SRR_W1;
  wire [7:0] in_next = qmode_q ? {in_sr_q[3:0], lanes_s} : {in_sr_q[6:0], lanes_s[0]};
  wire       in_done = rise && (in_cnt_q + iw == `SRR_BYTE_BITS);

  // Opcode acceptance depends on the lane mode latched for this frame.
  wire ok_read = !qmode_q && (in_next == `SRR_OPC_READ);
  wire ok_fast = (in_next == `SRR_OPC_FAST);
  wire ok_dual = !qmode_q && (in_next == `SRR_OPC_DUAL);
  wire ok_quad = !qmode_q && (in_next == `SRR_OPC_QUAD);

  reg [23:0] cfg_sel;
  reg [7:0]  min_dum;
  reg [3:0]  ow_sel;
  reg [3:0]  oe_sel;
  always @* begin
    cfg_sel = dummy_cfg_fast;
    min_dum = qmode_q ? `SRR_MIN_DUM_QUAD : `SRR_MIN_DUM_SPI;
    ow_sel  = qmode_q ? `SRR_W4 : `SRR_W1;
    oe_sel  = qmode_q ? `SRR_OE_W4 : `SRR_OE_W1;
    if (ok_read) begin
      cfg_sel = dummy_cfg_read;
      min_dum = `SRR_MIN_DUM_READ;
      ow_sel  = `SRR_W1;
      oe_sel  = `SRR_OE_W1;
    end else if (ok_dual) begin
      cfg_sel = dummy_cfg_dual;
      min_dum = `SRR_MIN_DUM_SPI;
      ow_sel  = `SRR_W2;
      oe_sel  = `SRR_OE_W2;
    end else if (ok_quad) begin
      cfg_sel = dummy_cfg_quad;
      min_dum = `SRR_MIN_DUM_SPI;
      ow_sel  = `SRR_W4;
      oe_sel  = `SRR_OE_W4;
    end
  end

  wire [7:0] init_cfg = cfg_sel[`SRR_DUM_INIT_LSB +: 8];
  wire [7:0] init_dum = (init_cfg < min_dum) ? min_dum : init_cfg;

  // The high bits of the byte go out first on whichever lanes are in use.
  function [3:0] lane_bits;
    input [7:0] u;
    input [3:0] w;
    begin
      case (w)
        `SRR_W2: lane_bits = {2'b00, u[7:6]};
        `SRR_W4: lane_bits = u[7:4];
        default: lane_bits = {2'b00, u[7], 1'b0};
      endcase
    end
  endfunction

  wire [7:0] snap_byte = snap_q[{bofs_q, 3'b000} +: 8];
  wire       len_empty = (pad_left_q == 2'b00) && (len_left_q == 14'h0000);
  wire [3:0] out_next  = out_cnt_q + ow_q;
  wire       unit_end  = (st_q == ST_DATA) && cur_data_q && !fin_q &&
                         (is_read_q ? (in_done && out_cnt_q == 4'h0)
                                    : (fall && out_cnt_q != 4'h0 &&
                                       out_next == `SRR_BYTE_BITS));
  wire       last_byte = is_read_q ? (in_next == `SRR_LAST_MARK) : len_empty;
  wire [11:0] dw_step  = (mode_q == `SRR_MODE_INC) ? dw_q + 12'h001 :
                         (mode_q == `SRR_MODE_DEC) ? dw_q - 12'h001 : dw_q;

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk_s;
    end
  end

  // Snapshot is only written by a fetch answer, so a live register cannot tear
  // while its bytes are shifted out.
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      snap_q <= 32'h00000000;
    end else if (mem_ack) begin
      snap_q <= mem_rdata;
    end
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q                <= ST_OPC;
      qmode_q             <= 1'b0;
      in_sr_q             <= 8'h00;
      in_cnt_q            <= 4'h0;
      is_read_q           <= 1'b0;
      ow_q                <= `SRR_W1;
      oe_mask_q           <= 4'h0;
      intra_q             <= 8'h00;
      inter_q             <= 8'h00;
      idum_q              <= 8'h00;
      mode_q              <= 2'b00;
      dw_q                <= 12'h000;
      bofs_q              <= 2'b00;
      pad_left_q          <= 2'b00;
      len_left_q          <= 14'h0000;
      out_sr_q            <= 8'h00;
      out_cnt_q           <= 4'h0;
      dum_left_q          <= 8'h00;
      cur_data_q          <= 1'b0;
      fin_q               <= 1'b0;
      mem_req             <= 1'b0;
      mem_addr            <= 14'h0000;
      quad_data_lanes_drv <= 4'h0;
      quad_data_lanes_oe  <= 4'h0;
      read_busy           <= 1'b0;
      bad_opcode          <= 1'b0;
    end else begin
      mem_req <= 1'b0;
      if (sel_idle) begin
        // Deselect drops all partial state and releases every lane.
        st_q               <= ST_OPC;
        in_cnt_q           <= 4'h0;
        out_cnt_q          <= 4'h0;
        fin_q              <= 1'b0;
        cur_data_q         <= 1'b0;
        quad_data_lanes_oe <= 4'h0;
        dum_left_q         <= 8'h00;
        read_busy          <= 1'b0;
        bad_opcode         <= 1'b0;
        qmode_q            <= quad_lane_mode;
      end else begin
        quad_data_lanes_oe <= (st_q == ST_DATA) ? oe_mask_q : 4'h0;
        read_busy          <= (st_q != ST_OPC) && (st_q != ST_SKIP);
        if (rise) begin
          in_sr_q  <= in_next;
          in_cnt_q <= (in_cnt_q + iw == `SRR_BYTE_BITS) ? 4'h0 : in_cnt_q + iw;
        end
        case (st_q)
          ST_OPC: if (in_done) begin
            if (ok_read || ok_fast || ok_dual || ok_quad) begin
              is_read_q <= ok_read;
              ow_q      <= ow_sel;
              oe_mask_q <= oe_sel;
              intra_q   <= cfg_sel[`SRR_DUM_INTRA_LSB +: 8];
              inter_q   <= cfg_sel[`SRR_DUM_INTER_LSB +: 8];
              idum_q    <= init_dum;
              st_q      <= ST_AH;
            end else begin
              bad_opcode <= 1'b1;
              st_q       <= ST_SKIP;
            end
          end
          ST_AH: if (in_done) begin
            mode_q    <= in_next[7:6];
            dw_q[11:6] <= in_next[5:0];
            st_q      <= ST_AL;
          end
          ST_AL: if (in_done) begin
            dw_q[5:0] <= in_next[7:2];
            mem_req   <= 1'b1;
            mem_addr  <= {dw_q[11:6], in_next[7:2], 2'b00};
            if (is_read_q) begin
              bofs_q     <= in_next[1:0];
              pad_left_q <= 2'b00;
              st_q       <= (idum_q == 8'h00) ? ST_DATA : ST_IDUM;
            end else begin
              bofs_q     <= 2'b00;
              pad_left_q <= in_next[1:0];
              st_q       <= ST_L1;
            end
          end
          ST_L1: if (in_done) begin
            if (in_next[`SRR_LEN_LONG_BIT]) begin
              len_left_q <= {in_next[5:0], 8'h00};
              st_q       <= ST_L2;
            end else begin
              len_left_q <= {7'h00, in_next[6:0]};
              st_q       <= ST_IDUM;
            end
          end
          ST_L2: if (in_done) begin
            len_left_q[7:0] <= in_next;
            st_q            <= ST_IDUM;
          end
          ST_IDUM: if (in_done) begin
            idum_q <= idum_q - 8'h01;
            if (idum_q == 8'h01) begin
              st_q <= ST_DATA;
            end
          end
          ST_DATA: begin
            if (fall && !fin_q) begin
              if (out_cnt_q == 4'h0) begin
                if (dum_left_q != 8'h00) begin
                  dum_left_q          <= dum_left_q - 8'h01;
                  cur_data_q          <= 1'b0;
                  quad_data_lanes_drv <= lane_bits(`SRR_DUMMY_BYTE, ow_q);
                  out_sr_q            <= `SRR_DUMMY_BYTE;
                  out_cnt_q           <= ow_q;
                end else if (!is_read_q && len_empty) begin
                  fin_q <= 1'b1;
                end else begin
                  cur_data_q          <= 1'b1;
                  quad_data_lanes_drv <= lane_bits(snap_byte, ow_q);
                  out_sr_q            <= snap_byte << ow_q;
                  out_cnt_q           <= ow_q;
                  if (pad_left_q != 2'b00) begin
                    pad_left_q <= pad_left_q - 2'b01;
                  end else if (!is_read_q) begin
                    len_left_q <= len_left_q - 14'h0001;
                  end
                end
              end else begin
                quad_data_lanes_drv <= lane_bits(out_sr_q, ow_q);
                out_sr_q            <= out_sr_q << ow_q;
                out_cnt_q           <= (out_next == `SRR_BYTE_BITS) ? 4'h0 : out_next;
              end
            end
            if (unit_end) begin
              if (last_byte) begin
                fin_q <= 1'b1;
              end else begin
                bofs_q <= bofs_q + 2'b01;
                if (bofs_q == `SRR_LAST_OFS) begin
                  // Boundary from the byte address just sent, then refetch.
                  dum_left_q <= inter_q;
                  dw_q       <= dw_step;
                  mem_req    <= 1'b1;
                  mem_addr   <= {dw_step, 2'b00};
                end else begin
                  dum_left_q <= intra_q;
                end
              end
            end
          end
          ST_SKIP: st_q <= ST_SKIP;
          default: begin
            st_q <= ST_SKIP;
          end
        endcase
      end
    end
  end

endmodule // srr_read_slave

// *** dv/srr_mem_model.sv ***
// Register store that answers the fetch port of the read slave.
`timescale 1ns/1ns
module srr_mem_model (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rstn,
  // Fetch port
  input  wire        mem_req,
  input  wire [13:0] mem_addr,
  output reg         mem_ack,
  output reg  [31:0] mem_rdata
);
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mem_ack   <= 1'b0;
      mem_rdata <= 32'h0;
    end else begin
      mem_ack   <= mem_req;
      // Data flips every idle cycle, so a copy not taken at the answer reads wrong.
      mem_rdata <= mem_req ? {~{2'h0, mem_addr}, 2'h0, mem_addr} : ~mem_rdata;
    end
  end
endmodule // srr_mem_model

// *** dv/srr_read_slave_asserts.sv ***
// Concurrent checks on the serial read slave ports.
`timescale 1ns/1ns
module srr_read_slave_asserts (
  // Clock and reset
  input wire        core_clk,
  input wire        rstn,
  // Link
  input wire        serial_clk,
  input wire        serial_select_n,
  input wire [3:0]  quad_data_lanes_drv,
  input wire [3:0]  quad_data_lanes_oe,
  // Fetch and status
  input wire        mem_req,
  input wire [13:0] mem_addr,
  input wire        read_busy,
  input wire        bad_opcode
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  lane_oe_legal_a: assert property (
    quad_data_lanes_oe inside {4'h0, 4'h2, 4'h3, 4'hF}) else $error("bad lane enable");
  deselect_release_a: assert property (
    serial_select_n [*6] |-> quad_data_lanes_oe == 4'h0) else $error("lanes kept");
  refused_quiet_a: assert property (
    bad_opcode |-> quad_data_lanes_oe == 4'h0) else $error("refused op drives");
  req_pulse_a: assert property (
    mem_req |=> !mem_req) else $error("fetch request too long");
  req_aligned_a: assert property (
    mem_req |-> mem_addr[1:0] == 2'h0) else $error("fetch address unaligned");
  abort_clear_a: assert property (
    serial_select_n [*6] |-> !bad_opcode && !read_busy) else $error("state kept");
  oe_hold_a: assert property (
    !serial_select_n [*4] ##0 quad_data_lanes_oe != 4'h0 |=> $stable(quad_data_lanes_oe))
    else $error("lane enable moved");
  drive_on_fall_a: assert property (
    $changed(quad_data_lanes_drv) && quad_data_lanes_oe != 4'h0
      |-> !serial_clk || !$past(serial_clk)) else $error("drive moved on rise");
endmodule // srr_read_slave_asserts

bind srr_read_slave srr_read_slave_asserts chk_u (
  .core_clk(core_clk), .rstn(rstn), .serial_clk(serial_clk),
  .serial_select_n(serial_select_n), .quad_data_lanes_drv(quad_data_lanes_drv),
  .quad_data_lanes_oe(quad_data_lanes_oe), .mem_req(mem_req), .mem_addr(mem_addr),
  .read_busy(read_busy), .bad_opcode(bad_opcode)
);

// *** dv/tb_srr_read_slave.sv ***
// Self-checking bench for the serial read slave.
`timescale 1ns/1ns
module tb_srr_read_slave;
  logic        core_clk;
  logic        rstn;
  logic        serial_clk;
  logic        serial_select_n;
  logic        quad_lane_mode;
  logic [3:0]  mst;
  logic [23:0] cfg_read, cfg_fast, cfg_dual, cfg_quad;
  wire  [3:0]  lanes_w, drv, oe;
  wire         mem_req, mem_ack, read_busy, bad_opcode;
  wire  [13:0] mem_addr;
  wire  [31:0] mem_rdata;
  int          failures;
  int          samples_checked;
  int          cycles;

  // Each lane carries whoever enables it; the master owns the rest.
  assign lanes_w = (oe & drv) | (~oe & mst);

  srr_read_slave dut_u (
    .core_clk(core_clk), .rstn(rstn), .serial_clk(serial_clk),
    .serial_select_n(serial_select_n), .quad_data_lanes(lanes_w),
    .quad_data_lanes_drv(drv), .quad_data_lanes_oe(oe), .quad_lane_mode(quad_lane_mode),
    .dummy_cfg_read(cfg_read), .dummy_cfg_fast(cfg_fast), .dummy_cfg_dual(cfg_dual),
    .dummy_cfg_quad(cfg_quad), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .read_busy(read_busy), .bad_opcode(bad_opcode)
  );
  srr_mem_model mem_u (
    .core_clk(core_clk), .rstn(rstn), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata)
  );

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // One byte on the link, w lanes a clock; returns what the slave drove.
  task automatic xb(input logic [7:0] b, input int w, output logic [7:0] g);
    logic [7:0] t;
    int i;
    g = 8'h00;
    for (i = 0; i < 8; i += w) begin
      t = b << i;
      mst = t[7:4] >> (4 - w);
      repeat (4) @(negedge core_clk);
      g = (g << w) | ((w == 1) ? {7'h0, lanes_w[1]} : {4'h0, lanes_w} & ((8'h01 << w) - 8'h01));
      serial_clk = 1'b1;
      repeat (4) @(negedge core_clk);
      serial_clk = 1'b0;
    end
  endtask

  task automatic desel();
    @(negedge core_clk);
    serial_select_n = 1'b1;
    repeat (6) @(negedge core_clk);
    check({4'h0, oe}, 8'h00);
    check({7'h0, bad_opcode}, 8'h00);
  endtask

  // Opens a frame, sends one header byte more, then gives up.
  task automatic cut(input logic [7:0] op, input logic q, input logic bad);
    logic [7:0] g;
    quad_lane_mode = q;
    @(negedge core_clk);
    serial_select_n = 1'b0;
    xb(op, q ? 4 : 1, g);
    xb(8'h40, q ? 4 : 1, g);
    repeat (4) @(negedge core_clk);
    check({7'h0, bad_opcode}, {7'h0, bad});
    check({7'h0, read_busy}, {7'h0, ~bad});
    check({4'h0, oe}, 8'h00);
    desel();
  endtask

  // A full read; n is the byte count of the basic read, ignored for length reads.
  task automatic frame(input logic [7:0] op, input logic q, input logic [15:0] a,
                       input logic [13:0] len, input int n);
    int w, ow, ofs, k, d;
    logic [11:0] dw;
    logic [23:0] c;
    logic [31:0] e;
    logic [7:0]  g;
    w = q ? 4 : 1;
    ow = (op == 8'h3B) ? 2 : (q || op == 8'h6B) ? 4 : 1;
    c = (op == 8'h03) ? cfg_read : (op == 8'h0B) ? cfg_fast : (op == 8'h3B) ? cfg_dual : cfg_quad;
    quad_lane_mode = q;
    @(negedge core_clk);
    serial_select_n = 1'b0;
    xb(op, w, g);
    xb(a[15:8], w, g);
    xb(a[7:0], w, g);
    ofs = a[1:0];
    if (op != 8'h03) begin
      n = len + a[1:0];
      ofs = 0;
      if (len > 14'h7F) begin
        xb({2'h2, len[13:8]}, w, g);
        xb(len[7:0], w, g);
      end else begin
        xb({1'b0, len[6:0]}, w, g);
      end
    end
    d = (op == 8'h03) ? 0 : q ? 3 : 1;
    if (c[7:0] > d) d = c[7:0];
    repeat (d) xb(8'h00, w, g);
    dw = a[13:2];
    for (k = 0; k < n; k++) begin
      xb((op == 8'h03 && k == n - 1) ? 8'hFF : 8'h00, ow, g);
      e = {~{2'h0, dw, 2'h0}, 2'h0, dw, 2'h0} >> (8 * ofs);
      check(g, e[7:0]);
      if (k == 0) check({4'h0, oe}, (ow == 1) ? 8'h02 : (ow == 2) ? 8'h03 : 8'h0F);
      if (k < n - 1) begin
        d = (ofs == 3) ? c[23:16] : c[15:8];
        repeat (d) begin
          xb(8'h00, ow, g);
          check(g, 8'h00);
        end
        if (ofs == 3) dw = (a[15:14] == 2'h1) ? dw + 12'h1 : (a[15:14] == 2'h2) ? dw - 12'h1 : dw;
      end
      ofs = (ofs + 1) % 4;
    end
    xb(8'h00, ow, g);
    check(g, (ow == 1) ? {8{e[0]}} : (ow == 2) ? {4{e[1:0]}} : {2{e[3:0]}});
    desel();
  endtask

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      finish_test();
    end
  end

  initial begin
    rstn = 1'b0;
    serial_clk = 1'b0;
    serial_select_n = 1'b1;
    quad_lane_mode = 1'b0;
    mst = 4'h0;
    cfg_read = 24'h010100;
    cfg_fast = 24'h020101;
    cfg_dual = 24'h010001;
    cfg_quad = 24'h000000;
    repeat (10) @(negedge core_clk);
    rstn = 1'b1;
    repeat (4) @(negedge core_clk);
    frame(8'h03, 1'b0, 16'h4010, 14'h0, 6);
    frame(8'h03, 1'b0, 16'h0007, 14'h0, 3);
    frame(8'h0B, 1'b0, 16'h8022, 14'h3, 0);
    frame(8'h0B, 1'b1, 16'h4100, 14'h82, 0);
    cut(8'h0B, 1'b0, 1'b0);
    frame(8'h3B, 1'b0, 16'h0030, 14'h6, 0);
    frame(8'h6B, 1'b0, 16'h4005, 14'h4, 0);
    cut(8'h03, 1'b1, 1'b1);
    cut(8'h3B, 1'b1, 1'b1);
    cut(8'h6B, 1'b1, 1'b1);
    cut(8'h5A, 1'b0, 1'b1);
    frame(8'h03, 1'b0, 16'h8004, 14'h0, 5);
    finish_test();
  end
endmodule // tb_srr_read_slave
